// ===== core/csr_bit_ctrl.v
// Bit-set / bit-clear state for board reset and system fail.
// Assumes at most one of set or clear writes in a given cycle.
`timescale 1ns/1ps
`include "vme_slave_window_defines.vh"

module csr_bit_ctrl (
  input  wire core_clk,
  input  wire rst_b,
  input  wire vme_rst_b,
  input  wire sysfail_power_opt,
  input  wire set_wr,
  input  wire clr_wr,
  input  wire from_vme,
  input  wire board_reset_bit,
  input  wire system_fail_bit,
  output reg  board_reset_r,
  output reg  system_fail_r
);

  wire reset_wr_ok;

  // Local-bus writes never touch the board reset
  assign reset_wr_ok = from_vme;

  always @(posedge core_clk) begin
    if (!rst_b || !vme_rst_b) begin
      board_reset_r <= 1'b0;
    end else if (set_wr && reset_wr_ok && board_reset_bit) begin
      board_reset_r <= 1'b1;
    end else if (clr_wr && reset_wr_ok && board_reset_bit) begin
      board_reset_r <= 1'b0;
    end
  end

  // Strap is caught by the synchronous reset, so every reset reloads it
  always @(posedge core_clk) begin
    if (!rst_b || !vme_rst_b) begin
      system_fail_r <= sysfail_power_opt;
    end else if (set_wr && system_fail_bit) begin
      system_fail_r <= 1'b1;
    end else if (clr_wr && system_fail_bit) begin
      system_fail_r <= 1'b0;
    end
  end

endmodule // csr_bit_ctrl

// ===== core/vme_slave_window_and_csr_ctrl.v
// Control registers and decode for one inbound VMEbus slave window,
// plus the CR/CSR bit-set, bit-clear and window base registers.
// Assumes register accesses are single-cycle strobes synchronous to
// core_clk, from either the VMEbus side or the local bus side.
`timescale 1ns/1ps
`include "vme_slave_window_defines.vh"

module vme_slave_window_and_csr_ctrl #(
  parameter AW = 32,
  parameter DW = 32,
  parameter RW = 12,
  parameter FW = 16
) (
  input  wire          core_clk,
  input  wire          rst_b,
  input  wire          vme_rst_b,
  input  wire          sysfail_power_opt,
  input  wire          pci_master_enable,
  input  wire          reg_wr,
  input  wire          reg_rd,
  input  wire          reg_from_vme,
  input  wire [RW-1:0] reg_addr,
  input  wire [DW-1:0] reg_wdata,
  output reg  [DW-1:0] reg_rdata_r,
  output reg           reg_rvalid_r,
  input  wire          vme_req,
  input  wire          vme_write,
  input  wire          vme_program,
  input  wire          vme_super,
  input  wire [2:0]    vme_space,
  input  wire          vme_cr_csr,
  input  wire [AW-1:0] vme_addr,
  output reg           win_claim_r,
  output reg           win_posted_r,
  output reg           win_prefetch_r,
  output reg  [1:0]    win_local_space_r,
  output reg  [AW-1:0] win_dest_addr_r,
  output reg           cfg_claim_r,
  output reg           local_reset_out_b_r,
  output reg           system_fail_line_r
);

  // Window control fields
  reg           image_en_r;
  reg           posted_write_enable_r;
  reg           prefetch_read_enable_r;
  reg  [1:0]    prog_data_sel_r;
  reg  [1:0]    priv_sel_r;
  reg  [2:0]    vme_space_sel_r;
  reg           wide_pci_en_r;
  reg           lock_rmw_en_r;
  reg  [1:0]    local_space_select_r;

  // Window address registers, upper halves only
  reg  [FW-1:0] window_lower_limit_r;
  reg  [FW-1:0] window_upper_limit_r;
  reg  [FW-1:0] address_translation_offset_r;

  // CR/CSR window base field
  reg  [4:0]    cfg_base_r;

  wire          any_rst;
  wire          wr_ctrl;
  wire          wr_base;
  wire          wr_bound;
  wire          wr_xlate;
  wire          wr_set;
  wire          wr_clr;
  wire          wr_cfg;
  wire          in_range;
  wire [AW-1:0] dest_addr;
  wire          board_reset;
  wire          system_fail;
  wire          mem_space;
  wire          win_claim_nxt;
  wire          cfg_claim_nxt;
  reg  [DW-1:0] rdata_nxt;

  assign any_rst  = !rst_b || !vme_rst_b;
  assign wr_ctrl  = reg_wr && (reg_addr == `OFS_WIN_CTRL);
  assign wr_base  = reg_wr && (reg_addr == `OFS_WIN_BASE);
  assign wr_bound = reg_wr && (reg_addr == `OFS_WIN_BOUND);
  assign wr_xlate = reg_wr && (reg_addr == `OFS_WIN_XLATE);
  assign wr_set   = reg_wr && (reg_addr == `OFS_CSR_BIT_SET);
  assign wr_clr   = reg_wr && (reg_addr == `OFS_CSR_BIT_CLEAR);
  assign wr_cfg   = reg_wr && (reg_addr == `OFS_CFG_WIN_BASE);

  // Control register: enables, AM filters and local space select
  always @(posedge core_clk) begin
    if (any_rst) begin
      image_en_r             <= 1'b0;
      posted_write_enable_r  <= 1'b0;
      prefetch_read_enable_r <= 1'b0;
      prog_data_sel_r        <= `RST_PROG_DATA;
      priv_sel_r             <= `RST_PRIV;
      vme_space_sel_r        <= `RST_VME_SPACE;
      wide_pci_en_r          <= 1'b0;
      lock_rmw_en_r          <= 1'b0;
      local_space_select_r   <= `RST_LOCAL_SPACE;
    end else if (wr_ctrl) begin
      image_en_r             <= reg_wdata[`CTL_IMAGE_EN_BIT];
      posted_write_enable_r  <= reg_wdata[`CTL_POSTED_WR_BIT];
      prefetch_read_enable_r <= reg_wdata[`CTL_PREFETCH_BIT];
      prog_data_sel_r        <=
        reg_wdata[`CTL_PROG_DATA_HI:`CTL_PROG_DATA_LO];
      priv_sel_r             <= reg_wdata[`CTL_PRIV_HI:`CTL_PRIV_LO];
      vme_space_sel_r        <=
        reg_wdata[`CTL_VME_SPACE_HI:`CTL_VME_SPACE_LO];
      wide_pci_en_r          <= reg_wdata[`CTL_WIDE_PCI_BIT];
      lock_rmw_en_r          <= reg_wdata[`CTL_LOCK_RMW_BIT];
      local_space_select_r   <=
        reg_wdata[`CTL_LOCAL_SPACE_HI:`CTL_LOCAL_SPACE_LO];
    end
  end

  // Base register; low half is reserved and not stored
  always @(posedge core_clk) begin
    if (any_rst) begin
      window_lower_limit_r <= `RST_WIN_ADDR;
    end else if (wr_base) begin
      window_lower_limit_r <= reg_wdata[`WIN_ADDR_HI:`WIN_ADDR_LO];
    end
  end

  // Bound register
  always @(posedge core_clk) begin
    if (any_rst) begin
      window_upper_limit_r <= `RST_WIN_ADDR;
    end else if (wr_bound) begin
      window_upper_limit_r <= reg_wdata[`WIN_ADDR_HI:`WIN_ADDR_LO];
    end
  end

  // Translation offset register
  always @(posedge core_clk) begin
    if (any_rst) begin
      address_translation_offset_r <= `RST_WIN_ADDR;
    end else if (wr_xlate) begin
      address_translation_offset_r <=
        reg_wdata[`WIN_ADDR_HI:`WIN_ADDR_LO];
    end
  end

  // CR/CSR base field
  always @(posedge core_clk) begin
    if (any_rst) begin
      cfg_base_r <= `RST_CFG_BASE;
    end else if (wr_cfg) begin
      cfg_base_r <= reg_wdata[`CFG_BASE_FIELD_HI:`CFG_BASE_FIELD_LO];
    end
  end

  csr_bit_ctrl u_csr_bits (
    .core_clk          (core_clk),
    .rst_b             (rst_b),
    .vme_rst_b         (vme_rst_b),
    .sysfail_power_opt (sysfail_power_opt),
    .set_wr            (wr_set),
    .clr_wr            (wr_clr),
    .from_vme          (reg_from_vme),
    .board_reset_bit   (reg_wdata[`CSR_BOARD_RESET_BIT]),
    .system_fail_bit   (reg_wdata[`CSR_SYSTEM_FAIL_BIT]),
    .board_reset_r     (board_reset),
    .system_fail_r     (system_fail)
  );

  window_decode #(
    .AW (AW),
    .FW (FW)
  ) u_decode (
    .src_addr      (vme_addr),
    .src_space     (vme_space),
    .src_program   (vme_program),
    .src_super     (vme_super),
    .lower_limit   (window_lower_limit_r),
    .upper_limit   (window_upper_limit_r),
    .xlate_offset  (address_translation_offset_r),
    .space_sel     (vme_space_sel_r),
    .prog_data_sel (prog_data_sel_r),
    .priv_sel      (priv_sel_r),
    .in_range      (in_range),
    .dest_addr     (dest_addr)
  );

  assign mem_space = (local_space_select_r == `LOCAL_SPACE_MEM);

  // Enable and bus-master gate both sit ahead of the address match
  assign win_claim_nxt = vme_req && !vme_cr_csr && in_range &&
                         image_en_r &&
                         pci_master_enable;

  // Field value zero is not a valid window, leaving thirty-one
  assign cfg_claim_nxt = vme_req && vme_cr_csr &&
                         (cfg_base_r != 5'h00) &&
                         (vme_addr[`CFG_ADDR_SEL_HI:`CFG_ADDR_SEL_LO] ==
                          cfg_base_r);

  // Decode results registered one cycle after the request
  always @(posedge core_clk) begin
    if (any_rst) begin
      win_claim_r       <= 1'b0;
      win_posted_r      <= 1'b0;
      win_prefetch_r    <= 1'b0;
      win_local_space_r <= `RST_LOCAL_SPACE;
      win_dest_addr_r   <= {AW{1'b0}};
      cfg_claim_r       <= 1'b0;
    end else begin
      win_claim_r       <= win_claim_nxt;
      // I/O and config cycles always stay coupled
      win_posted_r      <= win_claim_nxt && vme_write && mem_space &&
                           posted_write_enable_r;
      win_prefetch_r    <= win_claim_nxt && !vme_write && mem_space &&
                           prefetch_read_enable_r;
      win_local_space_r <= local_space_select_r;
      win_dest_addr_r   <= win_claim_nxt ? dest_addr : {AW{1'b0}};
      cfg_claim_r       <= cfg_claim_nxt;
    end
  end

  // Pin images: local reset is driven low while board reset is held
  always @(posedge core_clk) begin
    if (!rst_b) begin
      local_reset_out_b_r <= 1'b1;
      system_fail_line_r  <= 1'b0;
    end else begin
      local_reset_out_b_r <= !board_reset;
      system_fail_line_r  <= system_fail;
    end
  end

  // Read mux; unmapped and reserved bits read zero
  always @* begin
    rdata_nxt = {DW{1'b0}};
    case (reg_addr)
      `OFS_WIN_CTRL: begin
        rdata_nxt[`CTL_IMAGE_EN_BIT]  = image_en_r;
        rdata_nxt[`CTL_POSTED_WR_BIT] = posted_write_enable_r;
        rdata_nxt[`CTL_PREFETCH_BIT]  = prefetch_read_enable_r;
        rdata_nxt[`CTL_PROG_DATA_HI:`CTL_PROG_DATA_LO] = prog_data_sel_r;
        rdata_nxt[`CTL_PRIV_HI:`CTL_PRIV_LO] = priv_sel_r;
        rdata_nxt[`CTL_VME_SPACE_HI:`CTL_VME_SPACE_LO] = vme_space_sel_r;
        rdata_nxt[`CTL_WIDE_PCI_BIT]  = wide_pci_en_r;
        rdata_nxt[`CTL_LOCK_RMW_BIT]  = lock_rmw_en_r;
        rdata_nxt[`CTL_LOCAL_SPACE_HI:`CTL_LOCAL_SPACE_LO] =
          local_space_select_r;
      end
      `OFS_WIN_BASE: begin
        rdata_nxt[`WIN_ADDR_HI:`WIN_ADDR_LO] = window_lower_limit_r;
      end
      `OFS_WIN_BOUND: begin
        rdata_nxt[`WIN_ADDR_HI:`WIN_ADDR_LO] = window_upper_limit_r;
      end
      `OFS_WIN_XLATE: begin
        rdata_nxt[`WIN_ADDR_HI:`WIN_ADDR_LO] =
          address_translation_offset_r;
      end
      `OFS_CSR_BIT_CLEAR, `OFS_CSR_BIT_SET: begin
        rdata_nxt[`CSR_BOARD_RESET_BIT] = board_reset;
        rdata_nxt[`CSR_SYSTEM_FAIL_BIT] = system_fail;
        rdata_nxt[`CSR_BOARD_FAIL_BIT]  = `BOARD_FAIL_VALUE;
      end
      `OFS_CFG_WIN_BASE: begin
        rdata_nxt[`CFG_BASE_FIELD_HI:`CFG_BASE_FIELD_LO] = cfg_base_r;
      end
      default: begin
        rdata_nxt = {DW{1'b0}};
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (!rst_b) begin
      reg_rdata_r  <= {DW{1'b0}};
      reg_rvalid_r <= 1'b0;
    end else begin
      reg_rdata_r  <= reg_rd ? rdata_nxt : {DW{1'b0}};
      reg_rvalid_r <= reg_rd;
    end
  end

endmodule // vme_slave_window_and_csr_ctrl

// ===== core/vme_slave_window_defines.vh
// Register offsets, field positions and reset values for the slave
// window and CR/CSR control block. Definitions only.
`ifndef VME_SLAVE_WINDOW_DEFINES_VH
`define VME_SLAVE_WINDOW_DEFINES_VH

`define OFS_WIN_CTRL         12'hFCC
`define OFS_WIN_BASE         12'hFD0
`define OFS_WIN_BOUND        12'hFD4
`define OFS_WIN_XLATE        12'hFD8
`define OFS_CSR_BIT_CLEAR    12'hFF4
`define OFS_CSR_BIT_SET      12'hFF8
`define OFS_CFG_WIN_BASE     12'hFFC

`define CTL_IMAGE_EN_BIT     31
`define CTL_POSTED_WR_BIT    30
`define CTL_PREFETCH_BIT     29
`define CTL_PROG_DATA_HI     23
`define CTL_PROG_DATA_LO     22
`define CTL_PRIV_HI          21
`define CTL_PRIV_LO          20
`define CTL_VME_SPACE_HI     18
`define CTL_VME_SPACE_LO     16
`define CTL_WIDE_PCI_BIT     7
`define CTL_LOCK_RMW_BIT     6
`define CTL_LOCAL_SPACE_HI   1
`define CTL_LOCAL_SPACE_LO   0

`define WIN_ADDR_HI          31
`define WIN_ADDR_LO          16

`define CSR_BOARD_RESET_BIT  31
`define CSR_SYSTEM_FAIL_BIT  30
`define CSR_BOARD_FAIL_BIT   29

`define CFG_BASE_FIELD_HI    31
`define CFG_BASE_FIELD_LO    27
`define CFG_ADDR_SEL_HI      23
`define CFG_ADDR_SEL_LO      19

`define LOCAL_SPACE_MEM      2'h0
`define LOCAL_SPACE_IO       2'h1
`define LOCAL_SPACE_CFG      2'h2

`define RST_WIN_ADDR         16'h0000
`define RST_PROG_DATA        2'h3
`define RST_PRIV             2'h3
`define RST_VME_SPACE        3'h0
`define RST_LOCAL_SPACE      2'h0
`define RST_CFG_BASE         5'h00
`define BOARD_FAIL_VALUE     1'b0

`endif

// ===== core/window_decode.v
// Combinational address decode and translation for one slave window.
// Assumes all inputs are stable register values and a sampled address.
`timescale 1ns/1ps
`include "vme_slave_window_defines.vh"

module window_decode #(
  parameter AW = 32,
  parameter FW = 16
) (
  input  wire [AW-1:0] src_addr,
  input  wire [2:0]    src_space,
  input  wire          src_program,
  input  wire          src_super,
  input  wire [FW-1:0] lower_limit,
  input  wire [FW-1:0] upper_limit,
  input  wire [FW-1:0] xlate_offset,
  input  wire [2:0]    space_sel,
  input  wire [1:0]    prog_data_sel,
  input  wire [1:0]    priv_sel,
  output wire          in_range,
  output wire [AW-1:0] dest_addr
);

  wire [AW-1:0] base_full;
  wire [AW-1:0] bound_full;
  wire [AW-1:0] offset_full;
  wire          above_base;
  wire          below_bound;
  wire          am_ok;

  assign base_full   = {lower_limit, {(AW-FW){1'b0}}};
  assign bound_full  = {upper_limit, {(AW-FW){1'b0}}};
  assign offset_full = {xlate_offset, {(AW-FW){1'b0}}};

  assign above_base  = (src_addr >= base_full);
  // A zero bound opens the window to the top of the space
  assign below_bound = (upper_limit == {FW{1'b0}}) ||
                       (src_addr < bound_full);
  assign am_ok = (src_program ? prog_data_sel[1] : prog_data_sel[0]) &&
                 (src_super ? priv_sel[1] : priv_sel[0]) &&
                 (src_space == space_sel);
  assign in_range = above_base && below_bound && am_ok;

  // Modulo sum: negative offsets arrive as two's complement
  assign dest_addr = src_addr + offset_full;

endmodule // window_decode

// ===== verification/tb_vme_slave_window_and_csr_ctrl.sv
// Self-checking bench for the slave window and CSR control block.
// Assumes the bound checker and the backplane master model.
`timescale 1ns/1ps
module tb_vme_slave_window_and_csr_ctrl;
  logic        core_clk = 1'h0;
  logic        rst_b, vme_rst_b, sysfail_power_opt, pci_master_enable;
  logic        reg_wr, reg_rd, reg_from_vme, reg_rvalid_r;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_r, vme_addr, win_dest_addr_r;
  logic        vme_req, vme_write, vme_program, vme_super, vme_cr_csr;
  logic [2:0]  vme_space;
  logic        win_claim_r, win_posted_r, win_prefetch_r, cfg_claim_r;
  logic [1:0]  win_local_space_r;
  logic        local_reset_out_b_r, system_fail_line_r;
  int          failures = 0;
  int          num_checks = 0;
  int          cycles = 0;

  always #25 core_clk = ~core_clk;

  vme_slave_window_and_csr_ctrl u_dut (.core_clk, .rst_b, .vme_rst_b,
    .sysfail_power_opt, .pci_master_enable, .reg_wr, .reg_rd, .reg_from_vme,
    .reg_addr, .reg_wdata, .reg_rdata_r, .reg_rvalid_r, .vme_req, .vme_write,
    .vme_program, .vme_super, .vme_space, .vme_cr_csr, .vme_addr,
    .win_claim_r, .win_posted_r, .win_prefetch_r, .win_local_space_r,
    .win_dest_addr_r, .cfg_claim_r, .local_reset_out_b_r, .system_fail_line_r);

  vme_master_model u_vme (.core_clk, .vme_req, .vme_write, .vme_program,
    .vme_super, .vme_space, .vme_cr_csr, .vme_addr);

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d, input logic v);
    @(posedge core_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    reg_from_vme <= v;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask

  task rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1;
    chk(reg_rvalid_r, 32'h1);
    chk(reg_rdata_r, exp);
  endtask

  // Claim flags packed as cfg, claim, posted, prefetch
  task dec(input logic cr, input logic w, input logic [31:0] a,
           input logic [3:0] f, input logic [31:0] d);
    u_vme.cycle(cr, w, a);
    #1;
    chk({cfg_claim_r, win_claim_r, win_posted_r, win_prefetch_r}, f);
    chk(win_dest_addr_r, d);
  endtask

  task t_reset_values;
    rd(12'hFD0, 32'h0);
    rd(12'hFD4, 32'h0);
    rd(12'hFD8, 32'h0);
    rd(12'hFFC, 32'h0);
    rd(12'h100, 32'h0);
  endtask

  task t_window;
    @(posedge core_clk);
    pci_master_enable <= 1'h1;
    wr(12'hFD0, 32'h1000_ABCD, 1'h1);
    rd(12'hFD0, 32'h1000_0000);
    wr(12'hFD4, 32'h2000_0000, 1'h1);
    wr(12'hFD8, 32'h0001_0000, 1'h0);
    wr(12'hFCC, 32'hE0F2_0000, 1'h1);
    dec(1'h0, 1'h1, 32'h1000_0000, 4'h6, 32'h1001_0000);
    dec(1'h0, 1'h0, 32'h1FFF_FFFC, 4'h5, 32'h2000_FFFC);
    dec(1'h0, 1'h1, 32'h2000_0000, 4'h0, 32'h0);
    dec(1'h0, 1'h1, 32'h0FFF_FFFC, 4'h0, 32'h0);
    dec(1'h1, 1'h1, 32'h1000_0000, 4'h0, 32'h0);
    wr(12'hFD4, 32'h0, 1'h1);
    wr(12'hFD8, 32'hFFFF_0000, 1'h1);
    dec(1'h0, 1'h1, 32'hFFFF_0010, 4'h6, 32'hFFFE_0010);
  endtask

  task t_gates;
    for (int s = 1; s < 3; s++) begin
      wr(12'hFCC, 32'hE0F2_0000 | s, 1'h1);
      dec(1'h0, 1'h1, 32'h1000_0000, 4'h4, 32'h0FFF_0000);
      dec(1'h0, 1'h0, 32'h1000_0000, 4'h4, 32'h0FFF_0000);
      chk(win_local_space_r, s);
    end
    wr(12'hFCC, 32'h60F2_0000, 1'h1);
    dec(1'h0, 1'h1, 32'h1000_0000, 4'h0, 32'h0);
    wr(12'hFCC, 32'hE0F2_0000, 1'h1);
    pci_master_enable <= 1'h0;
    dec(1'h0, 1'h1, 32'h1000_0000, 4'h0, 32'h0);
    @(posedge core_clk);
    pci_master_enable <= 1'h1;
    // Data-only filter refuses a program cycle, then a space mismatch
    u_vme.set_am(1'h1, 1'h0, 3'h2);
    wr(12'hFCC, 32'hE072_0000, 1'h1);
    dec(1'h0, 1'h1, 32'h1000_0000, 4'h0, 32'h0);
    u_vme.set_am(1'h0, 1'h1, 3'h1);
    dec(1'h0, 1'h1, 32'h1000_0000, 4'h0, 32'h0);
    u_vme.set_am(1'h0, 1'h1, 3'h2);
    dec(1'h0, 1'h1, 32'h1000_0000, 4'h6, 32'h0FFF_0000);
  endtask

  task t_csr;
    wr(12'hFF8, 32'h8000_0000, 1'h0);
    wr(12'hFF8, 32'h2000_0000, 1'h1);
    idle(3);
    chk(local_reset_out_b_r, 32'h1);
    wr(12'hFF8, 32'h8000_0000, 1'h1);
    idle(3);
    chk(local_reset_out_b_r, 32'h0);
    rd(12'hFF4, 32'h8000_0000);
    wr(12'hFF4, 32'h0, 1'h1);
    wr(12'hFF4, 32'h8000_0000, 1'h0);
    idle(20);
    chk(local_reset_out_b_r, 32'h0);
    wr(12'hFF4, 32'h8000_0000, 1'h1);
    idle(3);
    chk(local_reset_out_b_r, 32'h1);
    rd(12'hFF8, 32'h0);
    wr(12'hFF8, 32'h4000_0000, 1'h0);
    idle(3);
    chk(system_fail_line_r, 32'h1);
    rd(12'hFF8, 32'h4000_0000);
    wr(12'hFF4, 32'h0, 1'h1);
    idle(3);
    chk(system_fail_line_r, 32'h1);
    wr(12'hFF4, 32'h4000_0000, 1'h1);
    idle(3);
    chk(system_fail_line_r, 32'h0);
  endtask

  task t_cfg;
    wr(12'hFFC, 32'h1800_0000, 1'h1);
    rd(12'hFFC, 32'h1800_0000);
    dec(1'h1, 1'h0, 32'h0018_0000, 4'h8, 32'h0);
    dec(1'h1, 1'h0, 32'h0020_0000, 4'h0, 32'h0);
  endtask

  task t_vme_reset;
    wr(12'hFF8, 32'h8000_0000, 1'h1);
    @(posedge core_clk);
    vme_rst_b <= 1'h0;
    sysfail_power_opt <= 1'h1;
    @(posedge core_clk);
    vme_rst_b <= 1'h1;
    idle(3);
    chk(local_reset_out_b_r, 32'h1);
    chk(system_fail_line_r, 32'h1);
    rd(12'hFD0, 32'h0);
    rd(12'hFD8, 32'h0);
    rd(12'hFFC, 32'h0);
  endtask

  task print_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Whole run needs under two hundred cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      print_verdict;
    end
  end

  initial begin
    rst_b = 1'h0;
    vme_rst_b = 1'h1;
    sysfail_power_opt = 1'h0;
    pci_master_enable = 1'h0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_from_vme = 1'h0;
    reg_addr = 12'h0;
    reg_wdata = 32'h0;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'h1;
    t_reset_values;
    t_window;
    t_gates;
    t_csr;
    t_cfg;
    t_vme_reset;
    print_verdict;
  end
endmodule // tb_vme_slave_window_and_csr_ctrl

// ===== verification/vme_master_model.sv
// Behavioural backplane master that issues decode requests.
// Assumes one caller at a time, from the bench's main thread.
`timescale 1ns/1ps
module vme_master_model (
  input  wire logic        core_clk,
  output logic             vme_req,
  output logic             vme_write,
  output logic             vme_program,
  output logic             vme_super,
  output logic [2:0]       vme_space,
  output logic             vme_cr_csr,
  output logic [31:0]      vme_addr
);
  initial begin
    vme_req = 1'h0;
    vme_write = 1'h0;
    vme_program = 1'h0;
    vme_super = 1'h1;
    vme_space = 3'h2;
    vme_cr_csr = 1'h0;
    vme_addr = 32'h0;
  end

  // Address-modifier and space qualifiers, held across later cycles
  task set_am(input logic p, input logic s, input logic [2:0] sp);
    @(posedge core_clk);
    vme_program <= p;
    vme_super <= s;
    vme_space <= sp;
  endtask

  task cycle(input logic cr, input logic wr, input logic [31:0] a);
    @(posedge core_clk);
    vme_req <= 1'h1;
    vme_write <= wr;
    vme_cr_csr <= cr;
    vme_addr <= a;
    @(posedge core_clk);
    vme_req <= 1'h0;
    // Released address must not look like a held one
    vme_addr <= ~a;
  endtask
endmodule // vme_master_model

// ===== verification/vme_win_chk.sv
// Port-level checker for the slave window and CSR control block.
// Sees only the top module's ports; bound in by name below.
`timescale 1ns/1ps
module vme_win_chk (
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        vme_rst_b,
  input wire logic        pci_master_enable,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic        reg_from_vme,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata_r,
  input wire logic        reg_rvalid_r,
  input wire logic        vme_req,
  input wire logic        vme_write,
  input wire logic        vme_cr_csr,
  input wire logic        win_claim_r,
  input wire logic        win_posted_r,
  input wire logic        win_prefetch_r,
  input wire logic [1:0]  win_local_space_r,
  input wire logic        local_reset_out_b_r,
  input wire logic        system_fail_line_r
);
  wire set_rst = reg_wr && reg_from_vme && reg_addr == 12'hFF8 &&
                 reg_wdata[31];
  wire clr_rst = reg_wr && reg_from_vme && reg_addr == 12'hFF4 &&
                 reg_wdata[31];
  wire clr_sf  = reg_wr && reg_addr == 12'hFF4 && reg_wdata[30];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  chk_claim_master: assert property (
    win_claim_r |-> $past(pci_master_enable))
    else $error("claim without master enable");
  chk_claim_cause: assert property (
    win_claim_r |-> $past(vme_req) && !$past(vme_cr_csr))
    else $error("claim without window request");
  chk_post_memory: assert property (win_posted_r |->
    win_claim_r && $past(vme_write) && win_local_space_r == 2'h0)
    else $error("posted outside memory write");
  chk_prefetch_memory: assert property (win_prefetch_r |->
    win_claim_r && !$past(vme_write) && win_local_space_r == 2'h0)
    else $error("prefetch outside memory read");
  chk_rvalid_follow: assert property (reg_rd |=> reg_rvalid_r)
    else $error("read not answered");
  chk_fail_zero: assert property (
    reg_rvalid_r && ($past(reg_addr) == 12'hFF4 ||
    $past(reg_addr) == 12'hFF8) |-> !reg_rdata_r[29])
    else $error("board fail bit not zero");
  chk_reset_cause: assert property ($fell(local_reset_out_b_r) |->
    $past(set_rst, 2) || $past(set_rst, 3))
    else $error("local reset without bus set write");
  chk_reset_hold: assert property ($rose(local_reset_out_b_r) |->
    $past(clr_rst, 2) || $past(clr_rst, 3) || !$past(vme_rst_b) ||
    !$past(vme_rst_b, 2))
    else $error("local reset released early");
  chk_sysfail_clear: assert property ($fell(system_fail_line_r) |->
    $past(clr_sf, 2) || $past(clr_sf, 3) || !$past(vme_rst_b) ||
    !$past(vme_rst_b, 2))
    else $error("system fail dropped without clear");
endmodule // vme_win_chk

bind vme_slave_window_and_csr_ctrl vme_win_chk u_chk (.core_clk, .rst_b,
  .vme_rst_b, .pci_master_enable, .reg_wr, .reg_rd, .reg_from_vme, .reg_addr,
  .reg_wdata, .reg_rdata_r, .reg_rvalid_r, .vme_req, .vme_write, .vme_cr_csr,
  .win_claim_r, .win_posted_r, .win_prefetch_r, .win_local_space_r,
  .local_reset_out_b_r, .system_fail_line_r);
